//--- src/asq_pkg.sv
// constants, carriers and decode functions for the converter sequencer
// What this block does
// - clock-select field picks bit period: osc/2, osc/8, osc/32 or private RC clock
// - channel-select field routes channel 0..3 to the sample-and-hold
// - with converter on, writing go=1 starts a conversion; go reads 1 while busy
// - hardware clears go when the conversion finishes, for software polling
// - converter-on bit powers the module; cleared means fully shut down
// - pin config sets analog/digital pins; 001, 011, 101 take external reference
// - pin config resets to 000: all pins analog, supply reference
// - reading a pin configured as analog returns zero
// - on completion load result, clear go, set done flag in one cycle
// - eight-bit result by successive approximation of the sample-and-hold output
// - after a conversion wait two bit periods with the capacitor disconnected
// - writing pin config may set pin-change and external-interrupt flags
// - unimplemented bits above the pin config field read as zero
// - holding capacitor is never discharged between conversions
// - conversion continues while the processor sleeps only with the RC clock; with a divider clock sleep aborts it
// - with the RC clock, start waits one instruction cycle after go
// - one conversion lasts nine and a half bit periods
// - clearing go aborts, keeps result, waits two periods, then re-acquires
package asq_pkg;

   localparam int          ADDR_W = 12;
   localparam logic [11:0] IDX_RESULT = 12'h01E;
   localparam logic [11:0] IDX_CTRL   = 12'h01F;
   localparam logic [11:0] IDX_STATUS = 12'h020;
   localparam logic [11:0] IDX_PORT   = 12'h021;
   localparam logic [11:0] IDX_PIN_ANALOG_CONFIG   = 12'h09F;
   localparam logic [11:0] ADDR_RESULT = {IDX_RESULT[9:0], 2'h0};
   localparam logic [11:0] ADDR_CTRL   = {IDX_CTRL[9:0], 2'h0};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'h0};
   localparam logic [11:0] ADDR_PORT   = {IDX_PORT[9:0], 2'h0};
   localparam logic [11:0] ADDR_PIN_ANALOG_CONFIG   = {IDX_PIN_ANALOG_CONFIG[9:0], 2'h0};

   localparam logic [1:0] CLK_DIV2  = 2'h0;
   localparam logic [1:0] CLK_DIV8  = 2'h1;
   localparam logic [1:0] CLK_DIV32 = 2'h2;
   localparam logic [1:0] CLK_RC    = 2'h3;
   // half bit period in oscillator cycles
   localparam logic [4:0] HALF_DIV2  = 5'h01;
   localparam logic [4:0] HALF_DIV8  = 5'h04;
   localparam logic [4:0] HALF_DIV32 = 5'h10;

   localparam logic [4:0] SETUP_HALF_TICKS = 5'h03;
   localparam logic [4:0] CONV_HALF_TICKS  = 5'h13;
   localparam logic [4:0] HOLD_HALF_TICKS  = 5'h04;
   localparam logic [4:0] INSTR_OSC_CYCLES = 5'h04;
   localparam logic [7:0] SAR_MSB = 8'h80;
   localparam logic [7:0] SAR_LSB = 8'h01;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [2:0] PIN_ANALOG_CONFIG_RESET = 3'h0;
   localparam int         GO_BIT     = 2;
   localparam int         ST_DONE    = 0;
   localparam int         ST_PINCHG  = 1;
   localparam int         ST_EXTIRQ  = 2;

   typedef struct packed {
      logic [1:0] conv_clock_select;
      logic       rsv5;
      logic [1:0] input_channel_select;
      logic       go;
      logic       rsv1;
      logic       converter_on;
   } asq_ctrl_s;

   typedef struct packed {
      logic       power_en;
      logic       hold_connect;
      logic [1:0] channel;
      logic       vref_external;
      logic [7:0] dac_code;
   } asq_afe_s;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_DELAY   = 3'h1,
      ST_SETUP   = 3'h3,
      ST_CONVERT = 3'h2,
      ST_HOLDOFF = 3'h6
   } asq_state_e;

   // bit i set: pin of channel i is analog (the reference pin counts as analog)
   function automatic logic [3:0] pin_analog_config_analog_mask(input logic [2:0] cfg);
      logic [3:0] m;
      m = 4'hF;
      case (cfg[2:1])
         2'h0: m = 4'hF;
         2'h1: m = 4'h7;
         2'h2: m = 4'h3;
         default: m = cfg[0] ? 4'h0 : 4'h1;
      endcase
      return m;
   endfunction

   function automatic logic pin_analog_config_vref_ext(input logic [2:0] cfg);
      return cfg[0] & (cfg != 3'h7);
   endfunction

endpackage

//--- src/asq_tad_tick.sv
// half bit-period tick from the oscillator divider or the private RC clock
`timescale 1ns/10ps
module asq_tad_tick
   import asq_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enable,
   input  wire logic [1:0] clk_sel,
   input  wire logic       rc_clk_pin,
   output logic            half_tick
);
   logic       rc_s1_reg, rc_s2_reg, rc_s3_reg;
   logic [4:0] div_reg, div_next, limit;

   always_comb
   begin
      unique case (clk_sel)
         CLK_DIV2:  limit = HALF_DIV2;
         CLK_DIV8:  limit = HALF_DIV8;
         CLK_DIV32: limit = HALF_DIV32;
         CLK_RC:    limit = HALF_DIV2;
      endcase
      // each RC edge is half a bit period, so both edges tick
      if (clk_sel == CLK_RC)
         half_tick = enable & (rc_s2_reg ^ rc_s3_reg);
      else
         half_tick = enable & (div_reg == limit - 5'h01);
      if (!enable || clk_sel == CLK_RC || half_tick)
         div_next = 5'h00;
      else
         div_next = div_reg + 5'h01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rc_s1_reg <= 1'b0;
         rc_s2_reg <= 1'b0;
         rc_s3_reg <= 1'b0;
         div_reg   <= 5'h00;
      end
      else
      begin
         rc_s1_reg <= rc_clk_pin;
         rc_s2_reg <= rc_s1_reg;
         rc_s3_reg <= rc_s2_reg;
         div_reg   <= div_next;
      end
   end
endmodule

//--- src/asq_sar.sv
// successive approximation register: one decision per step, MSB first
`timescale 1ns/10ps
module asq_sar
   import asq_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic       step,
   input  wire logic       cmp_above,
   output logic [7:0]      dac_code,
   output logic            last,
   output logic [7:0]      code_final
);
   logic [7:0] trial_reg, trial_next, mask_reg, mask_next;

   always_comb
   begin
      // keep the trial bit only while the held input is at or above the trial level
      code_final = cmp_above ? trial_reg : (trial_reg & ~mask_reg);
      last       = (mask_reg == SAR_LSB);
      trial_next = trial_reg;
      mask_next  = mask_reg;
      if (start)
      begin
         trial_next = SAR_MSB;
         mask_next  = SAR_MSB;
      end
      else if (step && !last)
      begin
         mask_next  = mask_reg >> 1;
         trial_next = code_final | (mask_reg >> 1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trial_reg <= 8'h00;
         mask_reg  <= 8'h00;
      end
      else
      begin
         trial_reg <= trial_next;
         mask_reg  <= mask_next;
      end
   end

   assign dac_code = trial_reg;
endmodule

//--- src/asq_adc_control.sv
// converter sequencer top: APB registers, conversion state machine, pin gating
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module asq_adc_control
   import asq_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              rc_clk_pin,
   input  wire logic              cmp_above_pin,
   input  wire logic [3:0]        gpio_pin_in,
   input  wire logic              cpu_sleep,
   output asq_afe_s               afe,
   output logic [3:0]             pin_analog_mask,
   output logic                   conversion_done_flag,
   output logic                   pin_change_flag,
   output logic                   external_irq_flag
);
   asq_ctrl_s  ctrl_reg, ctrl_next, wr_ctrl_val;
   asq_state_e state_reg, state_next;
   logic [2:0] pin_analog_config_reg, pin_analog_config_next;
   logic [7:0] result_reg, result_next;
   logic [4:0] cnt_reg, cnt_next;
   logic       done_reg, done_next;
   logic       pinchg_reg, pinchg_next;
   logic       extirq_reg, extirq_next;
   logic [31:0] prdata_reg, prdata_next;
   logic       slverr_reg, slverr_next;
   logic       cmp_s1_reg;
   logic [3:0] gpio_s1_reg, gpio_s2_reg;
   logic       wr_en, setup, wr_ctrl, wr_pin_analog_config, wr_result, wr_status;
   logic       rd_hit;
   logic [7:0] rd_val;
   logic [3:0] port_read;
   logic       sleep_off, busy, tick_en, half_tick, sar_start, sar_step;
   logic       sar_last;
   logic [7:0] sar_code, sar_dac;

   // pins from outside pass two flops before use; the comparator settles within one
   // pclk of a dac change, so one capture flop keeps a decision every second cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp_s1_reg  <= 1'b0;
         gpio_s1_reg <= 4'h0;
         gpio_s2_reg <= 4'h0;
      end
      else
      begin
         cmp_s1_reg  <= cmp_above_pin;
         gpio_s1_reg <= gpio_pin_in;
         gpio_s2_reg <= gpio_s1_reg;
      end
   end

   assign setup     = psel & ~penable;
   assign wr_en     = psel & penable & pwrite;
   assign wr_ctrl   = wr_en & (paddr == ADDR_CTRL);
   assign wr_pin_analog_config   = wr_en & (paddr == ADDR_PIN_ANALOG_CONFIG);
   assign wr_result = wr_en & (paddr == ADDR_RESULT);
   assign wr_status = wr_en & (paddr == ADDR_STATUS);
   assign wr_ctrl_val = asq_ctrl_s'(pwdata[7:0]);
   assign pready    = 1'b1;
   assign prdata    = prdata_reg;
   assign pslverr   = slverr_reg;

   assign pin_analog_mask = pin_analog_config_analog_mask(pin_analog_config_reg);
   assign port_read       = gpio_s2_reg & ~pin_analog_mask;
   // a non-RC clock stops in sleep, so the module is off though the on bit stays
   assign sleep_off = cpu_sleep & (ctrl_reg.conv_clock_select != CLK_RC);
   assign busy      = (state_reg == ST_DELAY) | (state_reg == ST_SETUP) |
                      (state_reg == ST_CONVERT);
   assign tick_en   = (state_reg != ST_IDLE) & (state_reg != ST_DELAY);
   assign sar_step  = (state_reg == ST_CONVERT) & half_tick & ~cnt_reg[0];

   // read decode; data is captured in the setup cycle
   always_comb
   begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      unique case (paddr)
         ADDR_CTRL:   rd_val = ctrl_reg;
         ADDR_PIN_ANALOG_CONFIG:   rd_val = {5'h00, pin_analog_config_reg};
         ADDR_RESULT: rd_val = result_reg;
         ADDR_STATUS: rd_val = {5'h00, extirq_reg, pinchg_reg, done_reg};
         ADDR_PORT:   rd_val = {4'h0, port_read};
         default:     rd_hit = 1'b0;
      endcase
      prdata_next = prdata_reg;
      slverr_next = slverr_reg;
      if (setup)
      begin
         prdata_next = {24'h000000, rd_val};
         slverr_next = ~rd_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h00000000;
         slverr_reg <= 1'b0;
      end
      else
      begin
         prdata_reg <= prdata_next;
         slverr_reg <= slverr_next;
      end
   end

   // conversion sequencing and register updates
   always_comb
   begin
      ctrl_next   = ctrl_reg;
      pin_analog_config_next   = pin_analog_config_reg;
      result_next = result_reg;
      done_next   = done_reg;
      pinchg_next = pinchg_reg;
      extirq_next = extirq_reg;
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      sar_start   = 1'b0;

      if (wr_ctrl)
      begin
         ctrl_next    = wr_ctrl_val;
         ctrl_next.go = ctrl_reg.go;
      end
      if (wr_result)
         result_next = pwdata[7:0];
      if (wr_status)
      begin
         done_next   = done_reg & pwdata[ST_DONE];
         pinchg_next = pinchg_reg & pwdata[ST_PINCHG];
         extirq_next = extirq_reg & pwdata[ST_EXTIRQ];
      end
      if (wr_pin_analog_config)
      begin
         pin_analog_config_next = pwdata[2:0];
         // a change of pin modes can glitch the pin inputs seen by the core
         if (pin_analog_config_analog_mask(pwdata[2:0]) != pin_analog_mask)
         begin
            pinchg_next = 1'b1;
            extirq_next = 1'b1;
         end
      end

      unique case (state_reg)
         ST_IDLE:
         begin
            // the on bit must already be set before this write
            if (wr_ctrl && wr_ctrl_val.go && ctrl_reg.converter_on && !sleep_off)
            begin
               ctrl_next.go = 1'b1;
               cnt_next     = 5'h00;
               if (wr_ctrl_val.conv_clock_select == CLK_RC)
                  state_next = ST_DELAY;
               else
                  state_next = ST_SETUP;
            end
         end
         ST_DELAY:
         begin
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == INSTR_OSC_CYCLES - 5'h01)
            begin
               cnt_next   = 5'h00;
               state_next = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            if (half_tick)
            begin
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == SETUP_HALF_TICKS - 5'h01)
               begin
                  sar_start  = 1'b1;
                  state_next = ST_CONVERT;
               end
            end
         end
         ST_CONVERT:
         begin
            if (half_tick)
               cnt_next = cnt_reg + 5'h01;
            if (sar_step && sar_last)
            begin
               result_next  = sar_code;
               ctrl_next.go = 1'b0;
               done_next    = 1'b1;
               cnt_next     = 5'h00;
               state_next   = ST_HOLDOFF;
            end
         end
         ST_HOLDOFF:
         begin
            if (half_tick)
            begin
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == HOLD_HALF_TICKS - 5'h01)
               begin
                  cnt_next   = 5'h00;
                  state_next = ST_IDLE;
               end
            end
         end
      endcase

      // abort paths; the result register is left as it was, except that clearing the on bit at the last step still loads it
      if (busy)
      begin
         if (wr_ctrl && !wr_ctrl_val.converter_on)
         begin
            ctrl_next.go = 1'b0;
            cnt_next     = 5'h00;
            state_next   = ST_IDLE;
         end
         else if ((wr_ctrl && !wr_ctrl_val.go) || sleep_off)
         begin
            ctrl_next.go = 1'b0;
            result_next  = wr_result ? pwdata[7:0] : result_reg;
            done_next    = wr_status ? (done_reg & pwdata[ST_DONE]) : done_reg;
            cnt_next     = 5'h00;
            state_next   = ST_HOLDOFF;
         end
      end
      else if (state_reg == ST_HOLDOFF && wr_ctrl && !wr_ctrl_val.converter_on)
      begin
         cnt_next   = 5'h00;
         state_next = ST_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg   <= asq_ctrl_s'(CTRL_RESET);
         pin_analog_config_reg   <= PIN_ANALOG_CONFIG_RESET;
         result_reg <= 8'h00;
         done_reg   <= 1'b0;
         pinchg_reg <= 1'b0;
         extirq_reg <= 1'b0;
         state_reg  <= ST_IDLE;
         cnt_reg    <= 5'h00;
      end
      else
      begin
         ctrl_reg   <= ctrl_next;
         pin_analog_config_reg   <= pin_analog_config_next;
         result_reg <= result_next;
         done_reg   <= done_next;
         pinchg_reg <= pinchg_next;
         extirq_reg <= extirq_next;
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
      end
   end

   asq_tad_tick u_tick (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (tick_en),
      .clk_sel    (ctrl_reg.conv_clock_select),
      .rc_clk_pin (rc_clk_pin),
      .half_tick  (half_tick)
   );

   asq_sar u_sar (
      .pclk       (pclk),
      .presetn    (presetn),
      .start      (sar_start),
      .step       (sar_step),
      .cmp_above  (cmp_s1_reg),
      .dac_code   (sar_dac),
      .last       (sar_last),
      .code_final (sar_code)
   );

   // front end: the sample switch is open from setup through the hold-off;
   // there is no discharge path, the capacitor keeps its charge between runs
   always_comb
   begin
      afe.power_en      = ctrl_reg.converter_on & ~sleep_off;
      afe.hold_connect  = afe.power_en &
                          ((state_reg == ST_IDLE) | (state_reg == ST_DELAY));
      afe.channel       = ctrl_reg.input_channel_select;
      afe.vref_external = pin_analog_config_vref_ext(pin_analog_config_reg);
      afe.dac_code      = sar_dac;
   end

   assign conversion_done_flag = done_reg;
   assign pin_change_flag      = pinchg_reg;
   assign external_irq_flag    = extirq_reg;

   a_go_needs_on: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_IDLE && wr_ctrl && !ctrl_reg.converter_on)
      |=> (state_reg == ST_IDLE && !ctrl_reg.go && $stable(result_reg)))
      else $error("go accepted while converter off");

   a_done_together: assert property (@(posedge pclk) disable iff (!presetn)
      (sar_step && sar_last && state_reg == ST_CONVERT && !wr_ctrl && !sleep_off)
      |=> (done_reg && !ctrl_reg.go && result_reg == $past(sar_code)))
      else $error("completion effects not simultaneous");

   a_abort_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      (busy && wr_ctrl && wr_ctrl_val.converter_on && !wr_ctrl_val.go && !wr_result)
      |=> (state_reg == ST_HOLDOFF && $stable(result_reg) && !ctrl_reg.go))
      else $error("abort changed result or missed hold-off");

   a_holdoff_open: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_HOLDOFF || state_reg == ST_CONVERT) |-> !afe.hold_connect)
      else $error("capacitor connected during conversion or hold-off");

   a_rc_delay: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_IDLE && $rose(ctrl_reg.go) == 1'b0 && wr_ctrl && wr_ctrl_val.go
       && ctrl_reg.converter_on && !sleep_off && wr_ctrl_val.conv_clock_select == CLK_RC)
      |=> (state_reg == ST_DELAY && ctrl_reg.go) [*4] ##1 (state_reg != ST_DELAY))
      else $error("RC start delay not one instruction cycle");

   a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
      (sar_step && sar_last) |-> (cnt_reg == CONV_HALF_TICKS - 5'h01))
      else $error("conversion not nine and a half bit periods");

   a_off_no_power: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_reg.converter_on |-> (!afe.power_en && !busy ##1 !busy))
      else $error("module active while converter off");

   a_analog_pins_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && paddr == ADDR_PORT) |=> ((prdata[3:0] & $past(pin_analog_mask)) == 4'h0))
      else $error("analog pin read as one");

   a_pin_analog_config_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && paddr == ADDR_PIN_ANALOG_CONFIG) |=> (prdata[31:3] == 29'h00000000))
      else $error("unimplemented pin config bits read nonzero");

   a_vref_route: assert property (@(posedge pclk) disable iff (!presetn)
      afe.vref_external == (pin_analog_config_reg == 3'h1 || pin_analog_config_reg == 3'h3 || pin_analog_config_reg == 3'h5))
      else $error("reference source mismatch");

   a_go_reads_busy: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_SETUP || state_reg == ST_CONVERT) |-> ctrl_reg.go)
      else $error("go flag low during conversion");
endmodule

//--- sim/asq_afe_model.sv
// analog pin side: per-channel levels, comparator and private RC oscillator
`timescale 1ns/10ps
module asq_afe_model
   import asq_pkg::*;
(
   input  asq_afe_s         afe,
   input  wire logic [31:0] vin_bus,
   output logic             cmp_above_pin,
   output logic             rc_clk_pin
);
   logic [7:0] held;

   initial rc_clk_pin = 1'b0;
   // runs free and slower than pclk, so the synchroniser sees every edge
   always #10 rc_clk_pin = ~rc_clk_pin;
   assign held = vin_bus[8*afe.channel +: 8];
   // settles at once after a dac change, well within one pclk
   assign cmp_above_pin = afe.power_en & (held >= afe.dac_code);
endmodule

//--- sim/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb
   import asq_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_sleep;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, vin_bus, rd;
   logic [3:0]  gpio_pin_in, pin_analog_mask;
   logic        cmp_above_pin, rc_clk_pin, done_f, er, pc_f, ei_f;
   asq_afe_s    afe;
   logic [7:0]  m_result;
   logic [3:0]  mtab [8] = '{4'hF, 4'hF, 4'h7, 4'h7, 4'h3, 4'h3, 4'h1, 4'h0};
   int          failures = 0;
   int          samples_checked = 0;

   always #2 pclk = ~pclk;

   asq_adc_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rc_clk_pin(rc_clk_pin), .cmp_above_pin(cmp_above_pin),
      .gpio_pin_in(gpio_pin_in), .cpu_sleep(cpu_sleep), .afe(afe),
      .pin_analog_mask(pin_analog_mask), .conversion_done_flag(done_f),
      .pin_change_flag(pc_f), .external_irq_flag(ei_f));
   asq_afe_model afe_m (.afe(afe), .vin_bus(vin_bus), .cmp_above_pin(cmp_above_pin),
      .rc_clk_pin(rc_clk_pin));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         chk(32'h0, 32'h1);
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic convert(input logic [1:0] cs, input logic [1:0] ch, input logic abort);
      int n;
      logic [7:0] c;
      c = {cs, 1'b0, ch, 3'h1};
      n = 0;
      apb(1'b1, ADDR_CTRL, {24'h0, c});
      repeat (8) @(posedge pclk);
      apb(1'b1, ADDR_CTRL, {24'h0, c | 8'h04});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, {24'h0, c | 8'h04});
      if (abort)
         apb(1'b1, ADDR_CTRL, {24'h0, c});
      else
         m_result = vin_bus[8*ch +: 8];
      do
      begin
         apb(1'b0, ADDR_CTRL, 32'h0);
         n++;
      end while (rd[2] !== 1'b0 && n < 400);
      chk({31'h0, n >= 400}, 32'h0);
      if (n >= 400)
         summarize();
      chk({31'h0, done_f}, {31'h0, ~abort});
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, {24'h0, m_result});
      apb(1'b1, ADDR_STATUS, 32'h0);
      // hold-off of two bit periods at the slowest divider is 64 cycles
      repeat (80) @(posedge pclk);
      chk({28'h0, afe.hold_connect, pc_f, ei_f, done_f}, 32'h8);
      $display("test conversion sel=%0d ch=%0d abort=%0d done", cs, ch, abort);
   endtask

   initial
   begin
      {pclk, presetn, psel, penable, pwrite, cpu_sleep} = 6'h00;
      {paddr, pwdata, vin_bus, gpio_pin_in} = 80'h0;
      m_result = 8'h00;
      void'($urandom(55670));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ADDR_PIN_ANALOG_CONFIG, 32'h0);
      chk(rd, 32'h0);
      chk({28'h0, pin_analog_mask}, 32'hF);
      apb(1'b1, ADDR_PIN_ANALOG_CONFIG, 32'hFF);
      apb(1'b0, ADDR_PIN_ANALOG_CONFIG, 32'h0);
      chk(rd, 32'h7);
      chk({30'h0, pc_f, ei_f}, 32'h3);
      apb(1'b0, 12'hFFC, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("test reset and map done");
      for (int k = 0; k < 8; k++)
      begin
         gpio_pin_in <= 4'($urandom);
         apb(1'b1, ADDR_PIN_ANALOG_CONFIG, k);
         repeat (3) @(posedge pclk);
         apb(1'b0, ADDR_PORT, 32'h0);
         chk(rd, {28'h0, gpio_pin_in & ~mtab[k]});
         chk({28'h0, pin_analog_mask}, {28'h0, mtab[k]});
         chk({31'h0, afe.vref_external}, {31'h0, k == 1 || k == 3 || k == 5});
      end
      $display("test pin config done");
      for (int cs = 0; cs < 4; cs++)
      begin
         vin_bus <= $urandom;
         cpu_sleep <= (cs == 3);
         convert(2'(cs), 2'($urandom), 1'b0);
         cpu_sleep <= 1'b0;
      end
      convert(CLK_DIV32, 2'h1, 1'b1);
      apb(1'b1, ADDR_CTRL, {24'h0, CLK_DIV32, 6'h01});
      repeat (8) @(posedge pclk);
      apb(1'b1, ADDR_CTRL, {24'h0, CLK_DIV32, 6'h05});
      cpu_sleep <= 1'b1;
      repeat (4) @(posedge pclk);
      chk({31'h0, afe.power_en}, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, {24'h0, CLK_DIV32, 6'h01});
      cpu_sleep <= 1'b0;
      repeat (80) @(posedge pclk);
      $display("test sleep abort done");
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h4);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      repeat (40) @(posedge pclk);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, {24'h0, m_result});
      chk({31'h0, done_f}, 32'h0);
      $display("test converter off done");
      summarize();
   end
endmodule
